// ### logic/cfsc_pkg.sv
// Operation
// - Channels start high impedance, output disabled
// - Current output functions enable adaptive rail switching
// - Lock field forces high-only or low-only rail
// - Tied rails force lock to high rail
// - Reference enable bit selects internal reference
// - Voltage output unipolar default, bipolar optional
// - One bit selects between two current limits
// - Voltage output short sets flag, asserts alert
// - High impedance ADC default 0 to 12V
// - Voltage output ADC default sense-resistor range
// - Sourced current negative, sunk current positive
// - Register writes fold into a running CRC check value
`default_nettype none
package cfsc_pkg;
	// ==================================================
	// Sizes
	localparam int unsigned NCH = 4;
	// ==================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_PWR = 8'h00;
	localparam logic [7:0] ADDR_ALERT_ST = 8'h04;
	localparam logic [7:0] ADDR_ALERT_MASK = 8'h08;
	localparam logic [7:0] ADDR_CRC = 8'h0c;
	localparam logic [7:0] BASE_FUNC = 8'h10;
	localparam logic [7:0] BASE_OUTCFG = 8'h20;
	localparam logic [7:0] BASE_BURN = 8'h30;
	localparam logic [7:0] BASE_DAC = 8'h40;
	localparam logic [7:0] BASE_RES_UPR = 8'h50;
	localparam logic [7:0] BASE_RES_LWR = 8'h60;
	localparam logic [7:0] BASE_STAT = 8'h70;
	localparam logic [7:0] ADDR_LIMIT = 8'h80;
	// ==================================================
	// Field positions
	localparam int unsigned PWR_REF_EN = 0;
	localparam int unsigned OUT_RANGE = 0;
	localparam int unsigned OUT_LOCK = 1;
	localparam int unsigned OUT_ILIM = 3;
	localparam int unsigned BRN_POL = 0;
	localparam int unsigned BRN_MAG = 1;
	// ==================================================
	// Codes and reset values
	localparam logic [3:0] FUNC_HIZ = 4'h0;
	localparam logic [3:0] FUNC_VOUT = 4'h1;
	localparam logic [3:0] FUNC_IOUT = 4'h2;
	localparam logic [3:0] FUNC_IOUT_HART = 4'h3;
	localparam logic [1:0] LOCK_ADAPTIVE = 2'h0;
	localparam logic [1:0] LOCK_HIGH = 2'h1;
	localparam logic [1:0] LOCK_LOW = 2'h2;
	localparam logic [1:0] ADC_RANGE_0_12V = 2'h0;
	localparam logic [1:0] ADC_RANGE_SENSE = 2'h1;
	localparam logic [23:0] RES_MIDSCALE = 24'h800000;
	localparam logic [NCH-1:0] MASK_RESET = 4'hf;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==================================================
	// ADC scaling for software
	localparam longint ADC_FULL_SCALE = 16777216;
	localparam int HIZ_SPAN_MV = 12000;
	localparam int VOUT_VMIN_UV = -312500;
	localparam int VOUT_SPAN_UV = 625000;
	localparam int RSENSE_OHM = 12;
	// ==================================================
	// Carriers
	typedef struct packed {
		logic [3:0] func;
		logic range;
		logic [1:0] lock;
		logic ilim;
		logic brn_pol;
		logic [1:0] brn_mag;
		logic [15:0] dac;
	} cfsc_chan_type;
	typedef struct packed {
		logic en;
		logic adaptive;
		logic lock_high;
		logic lock_low;
		logic bipolar;
		logic ilim;
		logic [1:0] adc_range;
	} cfsc_drive_type;
endpackage
`default_nettype wire

// ### logic/cfsc_top.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cfsc_top import cfsc_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Analog side inputs
	input wire logic [NCH-1:0] sc_detect_i,
	input wire logic rails_tied_i,
	input wire logic adc_valid_i,
	input wire logic [1:0] adc_chan_i,
	input wire logic [23:0] adc_code_i,
	// Analog side controls
	output cfsc_drive_type [NCH-1:0] chan_drive_o,
	output logic [NCH-1:0][15:0] dac_code_o,
	output logic internal_ref_en_o,
	output logic alert_n_o
);
	// ==================================================
	// State
	logic [NCH-1:0] sc_m, sc_s; // Short-circuit synchroniser
	logic tied_m, tied_s; // Rail tie synchroniser
	logic aw_hold, next_aw_hold; // Write address held
	logic w_hold, next_w_hold; // Write data held
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic ref_en, next_ref_en; // Internal reference select
	logic [NCH-1:0] flag, next_flag; // Sticky short flags
	logic [NCH-1:0] mask, next_mask; // Alert enables
	logic [NCH-1:0] w1c; // Flags cleared this cycle
	logic [NCH-1:0] sink; // Sense current is sunk
	logic alert_n, next_alert_n;
	logic [7:0] crc, next_crc; // Running write CRC
	cfsc_chan_type [NCH-1:0] chan, next_chan;
	cfsc_drive_type [NCH-1:0] drive, next_drive;
	logic [NCH-1:0][23:0] result, next_result;
	logic [31:0] wm; // Write data merged by strobes
	logic [31:0] bm; // Byte mask from strobes

	// ==================================================
	// Helpers
	// Per-channel register address
	function automatic logic [7:0] ch_addr(input logic [7:0] b, input int c);
		return b + 8'(c * 4);
	endfunction

	// Aligned and inside the map
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a < ADDR_LIMIT);
	endfunction

	// CRC-8 over one data word, msb first
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [31:0] d);
		logic [7:0] r;
		r = c;
		for (int k = 31; k >= 0; k--) begin
			r = {r[6:0], 1'b0} ^ (((r[7] ^ d[k]) == 1'b1) ? CRC_POLY : 8'h00);
		end
		return r;
	endfunction

	// Register read mux
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		if (a == ADDR_PWR) v[PWR_REF_EN] = ref_en;
		if (a == ADDR_ALERT_ST) v[NCH-1:0] = flag;
		if (a == ADDR_ALERT_MASK) v[NCH-1:0] = mask;
		if (a == ADDR_CRC) v[7:0] = crc;
		for (int c = 0; c < NCH; c++) begin
			if (a == ch_addr(BASE_FUNC, c)) v[3:0] = chan[c].func;
			if (a == ch_addr(BASE_OUTCFG, c)) begin
				v[OUT_RANGE] = chan[c].range;
				v[OUT_LOCK+:2] = chan[c].lock;
				v[OUT_ILIM] = chan[c].ilim;
			end
			if (a == ch_addr(BASE_BURN, c)) begin
				v[BRN_POL] = chan[c].brn_pol;
				v[BRN_MAG+:2] = chan[c].brn_mag;
			end
			if (a == ch_addr(BASE_DAC, c)) v[15:0] = chan[c].dac;
			if (a == ch_addr(BASE_RES_UPR, c)) v[7:0] = result[c][23:16];
			if (a == ch_addr(BASE_RES_LWR, c)) v[15:0] = result[c][15:0];
			if (a == ch_addr(BASE_STAT, c)) begin
				v[4:0] = {sink[c], drive[c].lock_low, drive[c].lock_high,
					drive[c].adaptive, drive[c].en};
			end
		end
		return v;
	endfunction

	// ==================================================
	// Outputs
	assign s_axi_awready_o = !aw_hold && !bvalid;
	assign s_axi_wready_o = !w_hold && !bvalid;
	assign s_axi_bvalid_o = bvalid;
	assign s_axi_bresp_o = bresp;
	assign s_axi_arready_o = !rvalid;
	assign s_axi_rvalid_o = rvalid;
	assign s_axi_rresp_o = rresp;
	assign s_axi_rdata_o = rdata;
	assign chan_drive_o = drive;
	assign internal_ref_en_o = ref_en;
	assign alert_n_o = alert_n;
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			dac_code_o[c] = chan[c].dac;
			// Midscale and above is a non-negative sense voltage: sinking
			sink[c] = (chan[c].func == FUNC_VOUT) && (result[c] >= RES_MIDSCALE);
		end
	end

	// ==================================================
	// Input synchronisers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sc_m <= '0;
			sc_s <= '0;
			tied_m <= 1'b0;
			tied_s <= 1'b0;
		end else begin
			sc_m <= sc_detect_i;
			sc_s <= sc_m;
			tied_m <= rails_tied_i;
			tied_s <= tied_m;
		end
	end

	// ==================================================
	// Bus, registers and channel control: next values
	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_ref_en = ref_en;
		next_mask = mask;
		next_crc = crc;
		next_chan = chan;
		next_result = result;
		w1c = '0;
		for (int b = 0; b < 4; b++) bm[b*8+:8] = {8{w_strb[b]}};
		wm = (rd_word(aw_addr) & ~bm) | (w_data & bm);
		// Take address and data in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
		end
		// Commit once both halves are held
		if (aw_hold && w_hold && !bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			// Every write folds into the check value; a CRC write restarts it
			next_crc = crc8_step(crc, w_data);
			if (aw_addr == ADDR_CRC) next_crc = CRC_RESET;
			if (aw_addr == ADDR_PWR) next_ref_en = wm[PWR_REF_EN];
			if (aw_addr == ADDR_ALERT_ST) w1c = wm[NCH-1:0];
			if (aw_addr == ADDR_ALERT_MASK) next_mask = wm[NCH-1:0];
			for (int c = 0; c < NCH; c++) begin
				// Software picks the function; hardware never leaves high-Z alone
				if (aw_addr == ch_addr(BASE_FUNC, c)) next_chan[c].func = wm[3:0];
				if (aw_addr == ch_addr(BASE_OUTCFG, c)) begin
					next_chan[c].range = wm[OUT_RANGE];
					next_chan[c].lock = wm[OUT_LOCK+:2];
					next_chan[c].ilim = wm[OUT_ILIM];
				end
				if (aw_addr == ch_addr(BASE_BURN, c)) begin
					next_chan[c].brn_pol = wm[BRN_POL];
					next_chan[c].brn_mag = wm[BRN_MAG+:2];
				end
				if (aw_addr == ch_addr(BASE_DAC, c)) next_chan[c].dac = wm[15:0];
			end
		end else if (bvalid && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		// Read answers one cycle after the address is taken
		if (s_axi_arvalid_i && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = mapped(s_axi_araddr_i) ? rd_word(s_axi_araddr_i) : 32'h0;
			next_rresp = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
		// Conversion results land in the channel they belong to
		if (adc_valid_i) next_result[adc_chan_i] = adc_code_i;
		for (int c = 0; c < NCH; c++) begin
			// A new short wins over a clear in the same cycle
			next_flag[c] = (flag[c] && !w1c[c]) ||
				(sc_s[c] && chan[c].func == FUNC_VOUT);
			next_drive[c].en = next_chan[c].func != FUNC_HIZ;
			next_drive[c].adaptive = (next_chan[c].func == FUNC_IOUT ||
				next_chan[c].func == FUNC_IOUT_HART) &&
				next_chan[c].lock == LOCK_ADAPTIVE && !tied_s;
			next_drive[c].lock_high = tied_s || next_chan[c].lock == LOCK_HIGH;
			next_drive[c].lock_low = !tied_s && next_chan[c].lock == LOCK_LOW;
			next_drive[c].bipolar = next_chan[c].range;
			next_drive[c].ilim = next_chan[c].ilim;
			// Voltage output measures the sense resistor, others the terminals
			next_drive[c].adc_range = (next_chan[c].func == FUNC_VOUT) ?
				ADC_RANGE_SENSE : ADC_RANGE_0_12V;
		end
		next_alert_n = ~|(next_flag & next_mask);
	end

	// ==================================================
	// Bus, registers and channel control: registers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0;
			ref_en <= 1'b0;
			flag <= '0;
			mask <= MASK_RESET;
			crc <= CRC_RESET;
			chan <= '0; // High-Z, unipolar, adaptive lock
			drive <= '0;
			result <= '0;
			alert_n <= 1'b1;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			ref_en <= next_ref_en;
			flag <= next_flag;
			mask <= next_mask;
			crc <= next_crc;
			chan <= next_chan;
			drive <= next_drive;
			result <= next_result;
			alert_n <= next_alert_n;
		end
	end

	// ==================================================
	// Assertions
	sequence s_wr_commit;
		aw_hold && w_hold && !bvalid;
	endsequence

	a_ref_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_commit ##0 (aw_addr == ADDR_PWR && w_strb[0]) |=>
		internal_ref_en_o == $past(w_data[PWR_REF_EN]))
		else $error("reference enable did not follow write");

	a_bresp_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_wr_commit |=> s_axi_bvalid_o [*1] ##0 (s_axi_bresp_o == RESP_OKAY) ==
		$past(mapped(aw_addr)))
		else $error("write response missing or wrong");

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		sequence s_sc_hit;
			sc_s[g] && chan[g].func == FUNC_VOUT && next_mask[g];
		endsequence
		a_hiz_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			next_chan[g].func == FUNC_HIZ |=> !chan_drive_o[g].en)
			else $error("high impedance channel enabled");
		a_iout_adapt: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			(next_chan[g].func == FUNC_IOUT || next_chan[g].func == FUNC_IOUT_HART) &&
			next_chan[g].lock == LOCK_ADAPTIVE && !tied_s |=>
			chan_drive_o[g].adaptive)
			else $error("current output without adaptive switching");
		a_lock_low: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			!tied_s && next_chan[g].lock == LOCK_LOW |=>
			chan_drive_o[g].lock_low && !chan_drive_o[g].adaptive)
			else $error("low rail lock ignored");
		a_tied_high: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			tied_s |=> chan_drive_o[g].lock_high && !chan_drive_o[g].lock_low &&
			!chan_drive_o[g].adaptive)
			else $error("tied rails did not force high lock");
		a_sc_alert: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			s_sc_hit |=> flag[g] && !alert_n_o)
			else $error("short circuit not flagged");
		a_flag_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			flag[g] && !w1c[g] |=> flag[g])
			else $error("short flag dropped without clear");
		a_range_map: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			next_chan[g].func == FUNC_VOUT |=> chan_drive_o[g].adc_range == ADC_RANGE_SENSE)
			else $error("sense range not selected");
		a_ilim_map: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
			1'b1 |=> chan_drive_o[g].ilim == $past(next_chan[g].ilim) &&
			chan_drive_o[g].bipolar == $past(next_chan[g].range))
			else $error("limit or range select not applied");
	end
endmodule
`default_nettype wire

// ### sim/cfsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfsc_host_model (
	// Clock
	input wire logic clk_i,
	// Write channels
	output logic [7:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	// Read channels
	output logic [7:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	// =========================================
	// Idle bus until the first request after power-up
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end
	// =========================================
	// One write: both channels offered, each held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic done, ta, tw;
		done = 1'b0;
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		while (!done) begin
			// Settled levels tell what the coming edge takes
			@(negedge clk_i);
			ta = awvalid_o && awready_i;
			tw = wvalid_o && wready_i;
			done = bvalid_i;
			resp = bresp_i;
			@(posedge clk_i);
			if (ta) awvalid_o <= 1'b0;
			if (tw) wvalid_o <= 1'b0;
			if (done) bready_o <= 1'b0;
		end
	endtask
	// =========================================
	// One read: address held until taken, data taken with rready
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done, ta;
		done = 1'b0;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		while (!done) begin
			@(negedge clk_i);
			ta = arvalid_o && arready_i;
			done = rvalid_i;
			d = rdata_i;
			resp = rresp_i;
			@(posedge clk_i);
			if (ta) arvalid_o <= 1'b0;
			if (done) rready_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import cfsc_pkg::*;;
	// =========================================
	// Bench signals
	logic core_clk, arst_n, tied, av;
	logic [NCH-1:0] sc;
	logic [1:0] ach, bresp, rresp, rs;
	logic [23:0] acode;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, iref, alert_n;
	logic [31:0] wdata, rdata, rv;
	cfsc_drive_type [NCH-1:0] drv;
	logic [NCH-1:0][15:0] dac;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	// =========================================
	// Clock, design and host
	always #20 core_clk = ~core_clk;
	cfsc_top dut_u (.core_clk_i(core_clk), .arst_n_i(arst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sc_detect_i(sc),
		.rails_tied_i(tied), .adc_valid_i(av), .adc_chan_i(ach), .adc_code_i(acode),
		.chan_drive_o(drv), .dac_code_o(dac), .internal_ref_en_o(iref), .alert_n_o(alert_n));
	cfsc_host_model host_u (.clk_i(core_clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready));
	// =========================================
	// Helpers
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		host_u.wr(a, d, rs);
		chk("bresp", 32'(er), 32'(rs));
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		host_u.rd(a, rv, rs);
		chk("rdata", e, rv);
		chk("rresp", 32'(er), 32'(rs));
	endtask
	task automatic dc(input int c, input logic [7:0] e);
		chk("drive", 32'(e), 32'(drv[c]));
	endtask
	task automatic adc(input logic [1:0] c, input logic [23:0] k);
		@(posedge core_clk);
		av <= 1'b1;
		ach <= c;
		acode <= k;
		@(posedge core_clk);
		av <= 1'b0;
	endtask
	// Reference CRC-8, msb first, seed zero
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end
	// =========================================
	// Main sequence
	initial begin
		{core_clk, arst_n, tied, av, sc, ach, acode} = '0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		// Power-up state
		for (int c = 0; c < NCH; c++) begin
			dc(c, 8'h00);
			r(BASE_STAT + 8'(4 * c), 32'h0, RESP_OKAY);
		end
		chk("alert_n", 32'h1, 32'(alert_n));
		chk("iref", 32'h0, 32'(iref));
		r(ADDR_ALERT_MASK, 32'hf, RESP_OKAY);
		// Reference select
		w(ADDR_PWR, 32'h1, RESP_OKAY);
		chk("iref", 32'h1, 32'(iref));
		// Current functions switch rails by themselves
		for (int c = 0; c < NCH; c++) begin
			w(BASE_FUNC + 8'(4 * c), 32'(c[0] ? FUNC_IOUT_HART : FUNC_IOUT), RESP_OKAY);
			dc(c, 8'hc0);
			r(BASE_STAT + 8'(4 * c), 32'h3, RESP_OKAY);
		end
		// Every lock code, ending adaptive again
		w(BASE_OUTCFG, 32'h2, RESP_OKAY);
		dc(0, 8'ha0);
		w(BASE_OUTCFG, 32'h4, RESP_OKAY);
		dc(0, 8'h90);
		w(BASE_OUTCFG, 32'h6, RESP_OKAY);
		dc(0, 8'h80);
		w(BASE_OUTCFG, 32'h0, RESP_OKAY);
		dc(0, 8'hc0);
		// Tied rails force the high rail
		tied <= 1'b1;
		repeat (4) @(posedge core_clk);
		dc(1, 8'ha0);
		tied <= 1'b0;
		repeat (4) @(posedge core_clk);
		dc(1, 8'hc0);
		// Bipolar voltage output in the safe order, then a unipolar one on channel 3
		w(BASE_DAC + 8'h08, 32'h8000, RESP_OKAY);
		w(BASE_OUTCFG + 8'h08, 32'h1, RESP_OKAY);
		w(BASE_FUNC + 8'h08, 32'(FUNC_VOUT), RESP_OKAY);
		dc(2, 8'h89);
		chk("dac", 32'h8000, 32'(dac[2]));
		w(BASE_OUTCFG + 8'h08, 32'h9, RESP_OKAY);
		dc(2, 8'h8d);
		w(BASE_FUNC + 8'h0c, 32'(FUNC_VOUT), RESP_OKAY);
		dc(3, 8'h81);
		// Short on a voltage and on a current channel
		sc <= 4'h5;
		repeat (5) @(posedge core_clk);
		chk("alert_n", 32'h0, 32'(alert_n));
		r(ADDR_ALERT_ST, 32'h4, RESP_OKAY);
		sc <= 4'h0;
		repeat (5) @(posedge core_clk);
		chk("alert_n", 32'h0, 32'(alert_n));
		w(ADDR_ALERT_ST, 32'h4, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		chk("alert_n", 32'h1, 32'(alert_n));
		// Masked flag leaves the alert quiet
		w(ADDR_ALERT_MASK, 32'h0, RESP_OKAY);
		sc <= 4'h4;
		repeat (5) @(posedge core_clk);
		chk("alert_n", 32'h1, 32'(alert_n));
		r(ADDR_ALERT_ST, 32'h4, RESP_OKAY);
		sc <= 4'h0;
		// Results and current direction
		adc(2'h2, 24'h800000);
		r(BASE_STAT + 8'h08, 32'h11, RESP_OKAY);
		adc(2'h2, 24'h7fffff);
		r(BASE_STAT + 8'h08, 32'h01, RESP_OKAY);
		r(BASE_RES_UPR + 8'h08, 32'h7f, RESP_OKAY);
		r(BASE_RES_LWR + 8'h08, 32'hffff, RESP_OKAY);
		// Idle burnout setting
		w(BASE_BURN + 8'h0c, 32'h4, RESP_OKAY);
		r(BASE_BURN + 8'h0c, 32'h4, RESP_OKAY);
		// Refused accesses
		w(8'h84, 32'h1, RESP_SLVERR);
		w(8'h42, 32'h1, RESP_SLVERR);
		r(8'h90, 32'h0, RESP_SLVERR);
		// Transfer check value
		w(ADDR_CRC, 32'h0, RESP_OKAY);
		w(BASE_DAC, 32'h1234, RESP_OKAY);
		r(ADDR_CRC, 32'(crc8(32'h1234)), RESP_OKAY);
		// Reset in mid-run returns every channel to high impedance
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int c = 0; c < NCH; c++) begin
			dc(c, 8'h00);
		end
		chk("iref", 32'h0, 32'(iref));
		chk("alert_n", 32'h1, 32'(alert_n));
		r(BASE_FUNC + 8'h08, 32'h0, RESP_OKAY);
		r(BASE_OUTCFG + 8'h08, 32'h0, RESP_OKAY);
		complete_run();
	end
endmodule
`default_nettype wire
